// *** core/tcif_pkg.sv ***
// Purpose: shared constants and types of the timer compare interrupt flag block
// Assumes: AHB-Lite word access, one clock hclk at 50 MHz
// Notes:   three 8-bit flag/enable groups plus control, status and mask words
package tcif_pkg;

  // register byte offsets
  localparam logic [7:0] TCIF_OFS_GRP0 = 8'h00;
  localparam logic [7:0] TCIF_OFS_GRP1 = 8'h04;
  localparam logic [7:0] TCIF_OFS_GRP2 = 8'h08;
  localparam logic [7:0] TCIF_OFS_CTRL = 8'h0C;
  localparam logic [7:0] TCIF_OFS_STAT = 8'h10;
  localparam logic [7:0] TCIF_OFS_MASK = 8'h14;

  // group register field positions
  localparam int unsigned TCIF_BIT_STD_CMPA_FLAG  = 7;
  localparam int unsigned TCIF_BIT_STD_PER_FLAG   = 6;
  localparam int unsigned TCIF_BIT_PER_CMPA_FLAG  = 5;
  localparam int unsigned TCIF_BIT_PER_PER_FLAG   = 4;
  localparam int unsigned TCIF_BIT_STD_CMPA_EN    = 3;
  localparam int unsigned TCIF_BIT_STD_PER_EN     = 2;
  localparam int unsigned TCIF_BIT_PER_CMPA_EN    = 1;
  localparam int unsigned TCIF_BIT_PER_PER_EN     = 0;
  localparam int unsigned TCIF_FLAG_LSB           = 4;
  localparam int unsigned TCIF_CTRL_GIE_BIT       = 0;

  // implemented bits per group
  localparam logic [7:0] TCIF_IMPL_FULL = 8'hFF;
  localparam logic [7:0] TCIF_IMPL_PER  = 8'h33;

  // reset values
  localparam logic [7:0]  TCIF_RST_GRP  = 8'h00;
  localparam logic [2:0]  TCIF_RST_STAT = 3'h0;
  localparam logic [2:0]  TCIF_RST_MASK = 3'h0;
  localparam logic [31:0] TCIF_RST_DATA = 32'h0000_0000;

  // bus encodings and group count
  localparam int unsigned TCIF_HTRANS_XFER_BIT = 1;
  localparam logic        TCIF_HRESP_OKAY      = 1'b0;
  localparam int unsigned TCIF_NUM_GRP         = 3;

  // events of one group, one bit each, same clock as the block
  typedef struct packed {
    logic std_cmpa;
    logic std_period;
    logic per_cmpa;
    logic per_period;
  } tcif_grp_evt_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } tcif_bus_st_t;

endpackage : tcif_pkg

// *** core/tcif_group.sv ***
// Purpose: one 8-bit flag/enable group register with its combined request
// Assumes: events and writes come from logic on the same clock
// Notes:   flags in bits 7..4, enables in bits 3..0, bits outside the mask read 0
`timescale 1ns/1ns
module tcif_group #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // software write
  input  wire logic                   wr_en,
  input  wire logic [7:0]             wr_data,
  // timer events
  input  wire tcif_pkg::tcif_grp_evt_t evt,
  // state
  output logic      [7:0]             value,
  output logic                        req
);

  typedef struct packed {
    logic [7:0] grp;
  } tcif_grp_state_t;

  tcif_grp_state_t st_reg;
  tcif_grp_state_t st_next;
  logic      [7:0] evt_bits;

  always_comb begin
    evt_bits = {evt, 4'h0};
    st_next  = st_reg;
    if (wr_en) begin
      st_next.grp = wr_data;
    end
    st_next.grp = (st_next.grp | evt_bits) & IMPL_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.grp <= tcif_pkg::TCIF_RST_GRP;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.grp & IMPL_MASK;
  assign req   = |(value[7:tcif_pkg::TCIF_FLAG_LSB] & value[tcif_pkg::TCIF_FLAG_LSB-1:0]);

endmodule : tcif_group

// *** core/tcif_top.sv ***
// Purpose: timer compare-match interrupt flag registers behind an AHB-Lite slave
// Assumes: timer events are same-clock pulses or levels; word accesses only
// Notes:   reads take one wait state, writes none; response is always OKAY
//
// Notes on behaviour
// - group0 bit7: std timer0 compare-A flag
// - group0 bit6: std timer0 period flag
// - group0 bits5,4: periodic timer0 flags
// - group0 bits3,2: std timer0 enables
// - group0 bits1,0: periodic timer0 enables
// - group1 bits7,6: std timer1 flags
// - group1 bits5,4: periodic timer1 flags
// - group1 bits3,2: std timer1 enables
// - group1 bits1,0: periodic timer1 enables
// - group2 bits5,4: periodic timer2 flags
// - group2 bits1,0: periodic timer2 enables
// - group2 bits7,6,3,2 read zero, unwritable
// - flag sets even while disabled
// - global enable low blocks irq; group_req is not gated by it
`timescale 1ns/1ns
module tcif_top (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // timer events
  input  wire tcif_pkg::tcif_grp_evt_t evt_grp0,
  input  wire tcif_pkg::tcif_grp_evt_t evt_grp1,
  input  wire logic                    per_timer2_cmpa_evt,
  input  wire logic                    per_timer2_period_evt,
  // requests to the cpu
  output logic      [2:0]              group_req,
  output logic                         irq
);

  typedef struct packed {
    tcif_pkg::tcif_bus_st_t bus_st;
    logic [7:0]             addr;
    logic                   addr_hit;
    logic                   word_ok;
    logic [31:0]            rdata;
    logic                   readyout;
    logic                   resp;
    logic                   gie;
    logic [2:0]             status;
    logic [2:0]             mask;
    logic [2:0]             group_req;
    logic                   irq;
  } tcif_top_state_t;

  tcif_top_state_t        st_reg;
  tcif_top_state_t        st_next;

  // group wiring
  logic [7:0]             grp_value [tcif_pkg::TCIF_NUM_GRP];
  logic [2:0]             grp_req;
  logic [2:0]             grp_wr;
  tcif_pkg::tcif_grp_evt_t evt_grp2;

  // bus decode helpers
  logic                   addr_phase;
  logic                   wr_phase;
  logic                   rd_phase;
  logic [31:0]            rd_mux;

  // group2 has no standard timer, its std events stay low
  always_comb begin
    evt_grp2            = '0;
    evt_grp2.per_cmpa   = per_timer2_cmpa_evt;
    evt_grp2.per_period = per_timer2_period_evt;
  end

  assign addr_phase = hsel & hready & htrans[tcif_pkg::TCIF_HTRANS_XFER_BIT];
  assign wr_phase   = (st_reg.bus_st == tcif_pkg::BUS_WRITE) & st_reg.addr_hit & st_reg.word_ok;
  assign rd_phase   = (st_reg.bus_st == tcif_pkg::BUS_READ);

  // group write strobes in the write data phase
  always_comb begin
    grp_wr    = 3'b000;
    grp_wr[0] = wr_phase & (st_reg.addr == tcif_pkg::TCIF_OFS_GRP0);
    grp_wr[1] = wr_phase & (st_reg.addr == tcif_pkg::TCIF_OFS_GRP1);
    grp_wr[2] = wr_phase & (st_reg.addr == tcif_pkg::TCIF_OFS_GRP2);
  end

  tcif_group #(
    .IMPL_MASK (tcif_pkg::TCIF_IMPL_FULL)
  ) u_grp0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (grp_wr[0]),
    .wr_data (hwdata[7:0]),
    .evt     (evt_grp0),
    .value   (grp_value[0]),
    .req     (grp_req[0])
  );

  tcif_group #(
    .IMPL_MASK (tcif_pkg::TCIF_IMPL_FULL)
  ) u_grp1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (grp_wr[1]),
    .wr_data (hwdata[7:0]),
    .evt     (evt_grp1),
    .value   (grp_value[1]),
    .req     (grp_req[1])
  );

  tcif_group #(
    .IMPL_MASK (tcif_pkg::TCIF_IMPL_PER)
  ) u_grp2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (grp_wr[2]),
    .wr_data (hwdata[7:0]),
    .evt     (evt_grp2),
    .value   (grp_value[2]),
    .req     (grp_req[2])
  );

  // read data selection, unmapped words read zero
  always_comb begin
    rd_mux = tcif_pkg::TCIF_RST_DATA;
    if (st_reg.addr_hit) begin
      case (st_reg.addr)
        tcif_pkg::TCIF_OFS_GRP0: begin
          rd_mux[7:0] = grp_value[0];
        end
        tcif_pkg::TCIF_OFS_GRP1: begin
          rd_mux[7:0] = grp_value[1];
        end
        tcif_pkg::TCIF_OFS_GRP2: begin
          rd_mux[7:0] = grp_value[2];
        end
        tcif_pkg::TCIF_OFS_CTRL: begin
          rd_mux[tcif_pkg::TCIF_CTRL_GIE_BIT] = st_reg.gie;
        end
        tcif_pkg::TCIF_OFS_STAT: begin
          rd_mux[2:0] = st_reg.status;
        end
        tcif_pkg::TCIF_OFS_MASK: begin
          rd_mux[2:0] = st_reg.mask;
        end
        default: begin
          rd_mux = tcif_pkg::TCIF_RST_DATA;
        end
      endcase
    end
  end

  always_comb begin
    st_next      = st_reg;
    st_next.resp = tcif_pkg::TCIF_HRESP_OKAY;

    // bus sequencing
    case (st_reg.bus_st)
      tcif_pkg::BUS_IDLE,
      tcif_pkg::BUS_WRITE: begin
        st_next.bus_st   = tcif_pkg::BUS_IDLE;
        st_next.readyout = 1'b1;
        if (addr_phase) begin
          st_next.addr     = haddr[7:0];
          st_next.addr_hit = (haddr[31:8] == 24'h00_0000);
          st_next.word_ok  = (hsize == 3'b010);
          if (hwrite) begin
            st_next.bus_st = tcif_pkg::BUS_WRITE;
          end else begin
            // one wait state so the read sees the last write
            st_next.bus_st   = tcif_pkg::BUS_READ;
            st_next.readyout = 1'b0;
          end
        end
      end
      tcif_pkg::BUS_READ: begin
        st_next.bus_st   = tcif_pkg::BUS_IDLE;
        st_next.readyout = 1'b1;
        st_next.rdata    = rd_mux;
      end
      default: begin
        st_next.bus_st   = tcif_pkg::BUS_IDLE;
        st_next.readyout = 1'b1;
      end
    endcase

    // control and mask writes
    if (wr_phase && st_reg.addr == tcif_pkg::TCIF_OFS_CTRL) begin
      st_next.gie = hwdata[tcif_pkg::TCIF_CTRL_GIE_BIT];
    end
    if (wr_phase && st_reg.addr == tcif_pkg::TCIF_OFS_MASK) begin
      st_next.mask = hwdata[2:0];
    end

    // status clears on read, a new request in the same cycle wins
    if (rd_phase && st_reg.addr_hit && st_reg.addr == tcif_pkg::TCIF_OFS_STAT) begin
      st_next.status = tcif_pkg::TCIF_RST_STAT;
    end
    st_next.status = st_next.status | grp_req;

    st_next.group_req = grp_req;
    st_next.irq = st_reg.gie & (|(st_reg.status & st_reg.mask));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.bus_st    <= tcif_pkg::BUS_IDLE;
      st_reg.addr      <= tcif_pkg::TCIF_OFS_GRP0;
      st_reg.addr_hit  <= 1'b0;
      st_reg.word_ok   <= 1'b0;
      st_reg.rdata     <= tcif_pkg::TCIF_RST_DATA;
      st_reg.readyout  <= 1'b1;
      st_reg.resp      <= tcif_pkg::TCIF_HRESP_OKAY;
      st_reg.gie       <= 1'b0;
      st_reg.status    <= tcif_pkg::TCIF_RST_STAT;
      st_reg.mask      <= tcif_pkg::TCIF_RST_MASK;
      st_reg.group_req <= 3'b000;
      st_reg.irq       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata    = st_reg.rdata;
  assign hreadyout = st_reg.readyout;
  assign hresp     = st_reg.resp;
  assign group_req = st_reg.group_req;
  assign irq       = st_reg.irq;

endmodule : tcif_top

// *** dv/tcif_checker_assertions.sv ***
// Purpose: port-level checks of the timer compare flag block
// Assumes: one AHB-Lite master, hready equal to hreadyout
// Notes:   bound to every tcif_top instance
`timescale 1ns/1ns
module tcif_checker (
  // clock and reset
  input wire logic                    hclk,
  input wire logic                    hresetn,
  // ahb-lite
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  // events and requests
  input wire tcif_pkg::tcif_grp_evt_t evt_grp0,
  input wire logic                    per_timer2_cmpa_evt,
  input wire logic                    per_timer2_period_evt,
  input wire logic [2:0]              group_req
);
  logic tk;
  logic rd2;
  logic w0;
  logic w2;
  assign tk  = hsel && hready && htrans[1];
  assign rd2 = tk && !hwrite && haddr == 32'h0000_0008;
  assign w0  = tk && hwrite && hsize == 3'b010 && haddr == 32'h0000_0000;
  assign w2  = tk && hwrite && hsize == 3'b010 && haddr == 32'h0000_0008;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_wait; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_wr_nowait; tk && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  property p_one_wait; $fell(hreadyout) |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("wait longer than one cycle");
  property p_grp2_rd; rd2 |-> ##2 hrdata[31:8] == 24'h00_0000 && hrdata[7:6] == 2'b00 && hrdata[3:2] == 2'b00;
  endproperty
  a_grp2_rd: assert property (p_grp2_rd)
    else $error("group2 unused bits set");
  property p_clr; w0 ##1 (hwdata[7:0] == 8'h00 && evt_grp0 == 4'h0) |-> ##2 !group_req[0]; endproperty
  a_clr: assert property (p_clr)
    else $error("group0 request after clear");
  property p_set; w0 ##1 hwdata[7:0] == 8'hFF |-> ##2 group_req[0]; endproperty
  a_set: assert property (p_set)
    else $error("group0 request missing");
  property p_grp2_wr;
    w2 ##1 (hwdata[7:0] == 8'hCC && !per_timer2_cmpa_evt && !per_timer2_period_evt) |-> ##2 !group_req[2];
  endproperty
  a_grp2_wr: assert property (p_grp2_wr)
    else $error("group2 unused bits took effect");
  property p_evt; w0 ##1 hwdata[7:0] == 8'h0F |-> ##2 group_req[0] == $past(|evt_grp0, 2); endproperty
  a_evt: assert property (p_evt)
    else $error("event beside enable write wrong");
  c_rd2: cover property (rd2);
  c_en: cover property (w0 ##1 hwdata[7:0] == 8'h0F);
  c_req: cover property ($rose(|group_req));
endmodule : tcif_checker

bind tcif_top tcif_checker u_tcif_checker (.*);

// *** dv/tcif_timer_model.sv ***
// Purpose: timer side model, fires compare events on request
// Assumes: events are one-cycle pulses on hclk
// Notes:   event lines stay low outside a request
`timescale 1ns/1ns
module tcif_timer_model (
  // clock and request
  input  wire logic                 hclk,
  input  wire logic                 fire,
  input  wire logic [9:0]           pat,
  // events to the block
  output tcif_pkg::tcif_grp_evt_t   e0,
  output tcif_pkg::tcif_grp_evt_t   e1,
  output logic                      p2a,
  output logic                      p2p
);
  initial {e0, e1, p2a, p2p} = 10'h000;
  always @(posedge hclk) begin
    {e0, e1, p2a, p2p} <= fire ? pat : 10'h000;
  end
endmodule : tcif_timer_model

// *** dv/tcif_top_tb_top.sv ***
// Purpose: directed bench for the timer compare flag block
// Assumes: one master, hready tied to hreadyout
// Notes:   fixed waits follow the block's stated latencies
`timescale 1ns/1ns
module tcif_top_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        fire = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [9:0]  pat = 10'h000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        p2a;
  logic        p2p;
  logic [2:0]  group_req;
  tcif_pkg::tcif_grp_evt_t e0;
  tcif_pkg::tcif_grp_evt_t e1;
  logic [7:0]  ofs [3];
  logic [7:0]  imp [3];
  int          n_fail = 0;
  int          checks_done = 0;
  always #10 hclk = ~hclk;
  tcif_top u_tcif_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt_grp0(e0), .evt_grp1(e1), .per_timer2_cmpa_evt(p2a),
    .per_timer2_period_evt(p2p), .group_req(group_req), .irq(irq));
  tcif_timer_model u_tcif_timer_model (.hclk(hclk), .fire(fire), .pat(pat), .e0(e0), .e1(e1),
    .p2a(p2a), .p2p(p2p));
  task give_verdict;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("[ERR] %s exp %h got %h", n, x, g);
      n_fail++;
    end
  endtask : chk
  // bounded wait for hready sampled high
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      give_verdict;
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk($sformatf("reg %h", a), x, r);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic req(input logic [2:0] x);
    repeat (4) @(posedge hclk);
    chk("group_req", {29'h0000_0000, x}, {29'h0000_0000, group_req});
  endtask : req
  task automatic ev(input logic [9:0] p);
    @(posedge hclk);
    fire <= 1'b1;
    pat <= p;
    @(posedge hclk);
    fire <= 1'b0;
  endtask : ev
  initial begin
    ofs = '{tcif_pkg::TCIF_OFS_GRP0, tcif_pkg::TCIF_OFS_GRP1, tcif_pkg::TCIF_OFS_GRP2};
    imp = '{tcif_pkg::TCIF_IMPL_FULL, tcif_pkg::TCIF_IMPL_FULL, tcif_pkg::TCIF_IMPL_PER};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0000_0000);
    $display("reset values done");
    for (int g = 0; g < 3; g++) begin
      wr(ofs[g], 32'h0000_00FF);
      rd(ofs[g], {24'h00_0000, imp[g]});
    end
    req(3'b111);
    wr(ofs[2], 32'h0000_00CC);
    rd(ofs[2], 32'h0000_0000);
    for (int g = 0; g < 2; g++) wr(ofs[g], 32'h0000_0000);
    req(3'b000);
    $display("field width done");
    wr(ofs[0], 32'h0000_000F);
    req(3'b000);
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 4; b++) begin
        if (g < 2 || b < 2) begin
          wr(ofs[g], 32'(8'h11 << b));
          rd(ofs[g], 32'(8'h11 << b));
          req(3'(1 << g));
          wr(ofs[g], 32'((8'h10 << b) | (8'h01 << ((b + 1) % 4))));
          req(3'b000);
          wr(ofs[g], 32'h0000_0000);
        end
      end
    end
    $display("enable pairing done");
    for (int i = 0; i < 10; i++) begin
      ev(10'(1 << i));
      rd(ofs[0], {24'h00_0000, pat[9:6], 4'h0});
      rd(ofs[1], {24'h00_0000, pat[5:2], 4'h0});
      rd(ofs[2], {26'h000_0000, pat[1:0], 4'h0});
      req(3'b000);
      for (int g = 0; g < 3; g++) wr(ofs[g], 32'h0000_0000);
    end
    $display("event flags done");
    rd(tcif_pkg::TCIF_OFS_STAT, 32'h0000_0007);
    ev(10'h3FF);
    wr(ofs[0], 32'h0000_00F8);
    wr(tcif_pkg::TCIF_OFS_CTRL, 32'h0000_0001);
    req(3'b001);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(tcif_pkg::TCIF_OFS_MASK, 32'h0000_0007);
    req(3'b001);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
    wr(tcif_pkg::TCIF_OFS_CTRL, 32'h0000_0000);
    req(3'b001);
    chk("irq gie off", 32'h0000_0000, {31'h0000_0000, irq});
    wr(tcif_pkg::TCIF_OFS_CTRL, 32'h0000_0001);
    for (int g = 0; g < 3; g++) wr(ofs[g], 32'h0000_0000);
    rd(tcif_pkg::TCIF_OFS_STAT, 32'h0000_0001);
    req(3'b000);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    rd(8'h40, 32'h0000_0000);
    $display("interrupt path done");
    give_verdict;
  end
endmodule : tcif_top_tb_top
